//--- idx_exec.v
// Executor for skip-on-null, absolute jump, OR literal and register increment
// Contract
// - Decrement-skip subtracts one; destination bit picks accumulator or register; no flag.
// - A zero decrement result turns the next instruction into a no-op.
// - Increment-skip adds one, stores by destination, no flag, skips on zero.
// - Absolute jump loads its 11-bit target into counter bits 10..0.
// - Jump fills counter bits 12..11 from page latch bits 4..3.
// - Absolute jump is unconditional, costs two cycles, touches no flag.
// - OR literal into accumulator, result to accumulator, zero flag updated.
// - Register increment stores by destination bit and updates zero flag.
`timescale 1ns/10ps
`include "idx_regs.vh"
module idx_exec #(
   parameter FILE_AW = 7
) (
   input wire clk, // 200 MHz core clock
   input wire reset_n, // Synchronous reset, active low
   input wire [4:0] avs_address, // Byte address
   input wire avs_read, // Read request
   input wire avs_write, // Write request
   input wire [31:0] avs_writedata, // Write data
   output reg [31:0] avs_readdata, // Read data
   output reg avs_waitrequest // Low for the accepting cycle
);
   // ----------------------------------------------------------------
   // State encoding
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_FETCH = 2'h1;
   localparam [1:0] ST_EXEC = 2'h2;

   reg [1:0] state_q;
   reg [13:0] instr_q;
   reg [7:0] acc_q;
   reg zero_q;
   reg skip_q;
   reg [4:0] page_q;
   reg [12:0] pc_q;
   reg [15:0] cycles_q;
   reg [FILE_AW-1:0] faddr_q;
   reg rd_valid_q;
   reg mem_we;
   reg [FILE_AW-1:0] mem_waddr;
   reg [7:0] mem_wdata;
   reg [31:0] rdmux;
   reg ready;
   wire [7:0] mem_rdata;
   wire [FILE_AW-1:0] mem_raddr;
   wire req;
   wire commit_wr;
   wire [5:0] op6;
   wire dest;
   wire [7:0] inc_res;
   wire [7:0] dec_res;

   function is_zero;
      input [7:0] v;
      begin
         is_zero = (v == 8'h00);
      end
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign req = avs_read | avs_write;
   assign commit_wr = avs_write & ~avs_waitrequest;
   assign op6 = instr_q[13:8];
   assign dest = instr_q[`IDX_DEST_BIT];
   // Wraps modulo 256 by width
   assign inc_res = mem_rdata + 8'h01;
   assign dec_res = mem_rdata - 8'h01;
   // While executing, the operand address comes from the instruction
   assign mem_raddr = (state_q == ST_IDLE) ? faddr_q : instr_q[FILE_AW-1:0];

   idx_file_mem #(
      .AW(FILE_AW),
      .DW(8)
   ) u_mem (
      .clk(clk),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr),
      .rd_data(mem_rdata)
   );

   // ----------------------------------------------------------------
   // Bus read mux and readiness
   // ----------------------------------------------------------------
   always @* begin
      rdmux = 32'h00000000;
      ready = 1'b1;
      case (avs_address)
         `IDX_OFS_INSTR: rdmux = {18'h00000, instr_q};
         `IDX_OFS_ACC: rdmux = {24'h000000, acc_q};
         `IDX_OFS_STATUS: rdmux = {29'h00000000, (state_q != ST_IDLE), skip_q, zero_q};
         `IDX_OFS_PAGE: rdmux = {27'h0000000, page_q};
         `IDX_OFS_PC: rdmux = {19'h00000, pc_q};
         `IDX_OFS_CYCLES: rdmux = {16'h0000, cycles_q};
         `IDX_OFS_FADDR: rdmux = {{(32-FILE_AW){1'b0}}, faddr_q};
         `IDX_OFS_FDATA: rdmux = {24'h000000, mem_rdata};
         default: rdmux = 32'h00000000;
      endcase
      // Hold off anything that would race an instruction in flight
      if (state_q != ST_IDLE) begin
         ready = 1'b0;
      end else if (avs_read && avs_address == `IDX_OFS_FDATA && !rd_valid_q) begin
         ready = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register file write port: bus or execute stage, never both
   // ----------------------------------------------------------------
   always @* begin
      mem_we = 1'b0;
      mem_waddr = faddr_q;
      mem_wdata = avs_writedata[7:0];
      if (state_q == ST_EXEC) begin
         mem_waddr = instr_q[FILE_AW-1:0];
         if (op6 == `IDX_OP_DSKIP) begin
            mem_we = dest;
            mem_wdata = dec_res;
         end else if (op6 == `IDX_OP_ISKIP || op6 == `IDX_OP_INC) begin
            mem_we = dest;
            mem_wdata = inc_res;
         end
      end else if (commit_wr && avs_address == `IDX_OFS_FDATA) begin
         mem_we = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Bus handshake: one low cycle of waitrequest per request
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         rd_valid_q <= 1'b0;
      end else begin
         if (req && avs_waitrequest && ready) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rdmux;
         end else begin
            avs_waitrequest <= 1'b1;
         end
         // Read data are good one edge after the address last moved
         rd_valid_q <= (state_q == ST_IDLE) && !(commit_wr &&
            (avs_address == `IDX_OFS_FADDR || avs_address == `IDX_OFS_FDATA ||
             avs_address == `IDX_OFS_INSTR));
      end
   end

   // ----------------------------------------------------------------
   // Software registers and the instruction sequencer
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         instr_q <= 14'h0000;
         acc_q <= `IDX_RST_ACC;
         zero_q <= 1'b0;
         skip_q <= 1'b0;
         page_q <= `IDX_RST_PAGE;
         pc_q <= `IDX_RST_PC;
         cycles_q <= 16'h0000;
         faddr_q <= {FILE_AW{1'b0}};
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (commit_wr) begin
                  case (avs_address)
                     `IDX_OFS_INSTR: begin
                        instr_q <= avs_writedata[13:0];
                        if (skip_q) begin
                           // Discarded word runs as a no-op cycle
                           skip_q <= 1'b0;
                           cycles_q <= cycles_q + `IDX_CYC_ONE;
                           pc_q <= pc_q + 13'h0001;
                        end else begin
                           state_q <= ST_FETCH;
                        end
                     end
                     `IDX_OFS_ACC: acc_q <= avs_writedata[7:0];
                     `IDX_OFS_STATUS: zero_q <= avs_writedata[`IDX_ST_ZERO];
                     `IDX_OFS_PAGE: page_q <= avs_writedata[4:0];
                     `IDX_OFS_PC: pc_q <= avs_writedata[12:0];
                     `IDX_OFS_FADDR: faddr_q <= avs_writedata[FILE_AW-1:0];
                     default: faddr_q <= faddr_q;
                  endcase
               end
            end
            // Operand read is registered inside the memory
            ST_FETCH: state_q <= ST_EXEC;
            ST_EXEC: begin
               state_q <= ST_IDLE;
               cycles_q <= cycles_q + `IDX_CYC_ONE;
               pc_q <= pc_q + 13'h0001;
               if (op6 == `IDX_OP_DSKIP) begin
                  if (!dest) begin
                     acc_q <= dec_res;
                  end
                  skip_q <= is_zero(dec_res);
               end else if (op6 == `IDX_OP_ISKIP) begin
                  if (!dest) begin
                     acc_q <= inc_res;
                  end
                  skip_q <= is_zero(inc_res);
               end else if (op6 == `IDX_OP_INC) begin
                  if (!dest) begin
                     acc_q <= inc_res;
                  end
                  zero_q <= is_zero(inc_res);
               end else if (instr_q[13:11] == `IDX_OP_JUMP) begin
                  // Branch flushes the fetched word, hence two cycles
                  pc_q <= {page_q[`IDX_PAGE_HI:`IDX_PAGE_LO], instr_q[10:0]};
                  cycles_q <= cycles_q + `IDX_CYC_TWO;
               end else if (op6 == `IDX_OP_ORLIT) begin
                  acc_q <= acc_q | instr_q[7:0];
                  zero_q <= is_zero(acc_q | instr_q[7:0]);
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // idx_exec

//--- idx_exec_chk.sv
// Bus-side assertions for the instruction executor
`timescale 1ns/10ps
`include "idx_regs.vh"
module idx_exec_chk (
   input wire clk, // Core clock
   input wire reset_n, // Sync reset, low
   input wire [4:0] avs_address, // Address
   input wire avs_read, // Read
   input wire avs_write, // Write
   input wire [31:0] avs_readdata, // Read data
   input wire avs_waitrequest // Wait
);
   // Acceptance strobes seen at the bus
   wire ack = !avs_waitrequest;
   wire rd_ok = avs_read && ack;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_ack_single: assert property (ack |=> !ack)
      else $error("ack held two cycles");
   a_no_idle_ack: assert property (!avs_read && !avs_write |=> !ack)
      else $error("ack without request");
   // Read data are loaded on the edge that drops waitrequest, so they may only
   // move into an acknowledge cycle and must stand still in every other one
   a_read_hold: assert property (!ack |-> $stable(avs_readdata))
      else $error("read data moved");
   a_acc_width: assert property (
      rd_ok && avs_address == `IDX_OFS_ACC |-> avs_readdata[31:8] == 24'h0)
      else $error("acc wider than 8 bits");
   a_pc_width: assert property (
      rd_ok && avs_address == `IDX_OFS_PC |-> avs_readdata[31:13] == 19'h0)
      else $error("pc wider than 13 bits");
   a_file_width: assert property (
      rd_ok && avs_address == `IDX_OFS_FDATA |-> avs_readdata[31:8] == 24'h0)
      else $error("file entry wider than 8 bits");
   a_status_idle: assert property (
      rd_ok && avs_address == `IDX_OFS_STATUS |-> avs_readdata[31:2] == 30'h0)
      else $error("busy seen by a read");
   a_unmapped_zero: assert property (
      rd_ok && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   c_instr: cover property (avs_write && ack && avs_address == `IDX_OFS_INSTR);
   c_status: cover property (rd_ok && avs_address == `IDX_OFS_STATUS);
   c_unmapped: cover property (rd_ok && avs_address[1:0] != 2'h0);
endmodule // idx_exec_chk

//--- idx_exec_tb.sv
// Self-checking bench for the instruction executor
`timescale 1ns/10ps
`include "idx_regs.vh"
module idx_exec_tb;
   logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [13:0] ins;
   int n_errors = 0;
   int checks = 0;
   int acc, z, skp, pg, pc, cyc, fa, fv, op, d, k, r, i;
   idx_exec u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   idx_host u_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task finish_test;
      begin
         $display("checks %0d errors %0d", checks, n_errors);
         if (n_errors == 0 && checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // Bus access; a lost answer ends the run
   task automatic xf(input bit w, input logic [4:0] a, input logic [31:0] v,
      output logic [31:0] q);
      bit late;
      begin
         u_host.xfer(w, a, v, q, late);
         if (late) begin
            n_errors++;
            $display("[ERR] wait %h exp 0 got 1", a);
            finish_test;
         end
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      logic [31:0] q;
      xf(1'b1, a, v, q);
   endtask
   task automatic chk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      begin
         xf(1'b0, a, 32'h0, q);
         checks++;
         if (q !== e) begin
            n_errors++;
            $display("[ERR] reg %h exp %h got %h", a, e, q);
         end
      end
   endtask
   // Random instructions against an integer model of the core
   initial begin
      reset_n = 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      void'($urandom(32'h63a7));
      for (i = 0; i < 28; i += 4) chk(i[4:0], 32'h0);
      {acc, z, skp, pg, pc, cyc} = '0;
      for (i = 0; i < 90; i++) begin
         fa = $urandom % 128;
         fv = ($urandom % 3 == 0) ? (($urandom % 2) ? 1 : 255) : $urandom % 256;
         acc = $urandom % 256;
         pg = $urandom % 32;
         z = $urandom % 2;
         op = $urandom % 6;
         d = $urandom % 2;
         k = $urandom % 2048;
         wr(`IDX_OFS_FADDR, fa);
         wr(`IDX_OFS_FDATA, fv);
         wr(`IDX_OFS_ACC, acc);
         wr(`IDX_OFS_PAGE, pg);
         wr(`IDX_OFS_STATUS, z);
         case (op)
            0: ins = {`IDX_OP_DSKIP, d[0], fa[6:0]};
            1: ins = {`IDX_OP_ISKIP, d[0], fa[6:0]};
            2: ins = {`IDX_OP_INC, d[0], fa[6:0]};
            3: ins = {`IDX_OP_JUMP, k[10:0]};
            4: ins = {`IDX_OP_ORLIT, k[7:0]};
            default: ins = 14'h0;
         endcase
         wr(`IDX_OFS_INSTR, ins);
         r = (op == 0) ? (fv + 255) % 256 : (op == 4) ? (acc | k % 256) : (fv + 1) % 256;
         if (skp) skp = 0;
         else if (op == 3) begin
            pc = pg / 8 * 2048 + k - 1;
            cyc++;
         end else if (op < 3) begin
            if (d) fv = r;
            else acc = r;
            if (op < 2) skp = (r == 0);
            else z = (r == 0);
         end else if (op == 4) begin
            acc = r;
            z = (r == 0);
         end
         pc = (pc + 1) % 8192;
         cyc = (cyc + 1) % 65536;
         chk(`IDX_OFS_ACC, acc);
         chk(`IDX_OFS_STATUS, skp * 2 + z);
         chk(`IDX_OFS_PC, pc);
         chk(`IDX_OFS_CYCLES, cyc);
         chk(`IDX_OFS_FDATA, fv);
      end
      // Software side of the map: counter load, instruction readback, file window
      pc = $urandom % 8192;
      wr(`IDX_OFS_PC, pc);
      chk(`IDX_OFS_PC, pc);
      chk(`IDX_OFS_INSTR, ins);
      // Read right after the address moves; the host's release edge already covers the wait cycle
      wr(`IDX_OFS_FADDR, fa);
      chk(`IDX_OFS_FDATA, fv);
      chk(`IDX_OFS_FADDR, fa);
      wr(`IDX_OFS_CYCLES, 32'h1234);
      chk(`IDX_OFS_CYCLES, cyc);
      wr(5'h02, 32'hff);
      chk(5'h02, 32'h0);
      finish_test;
   end
endmodule // idx_exec_tb
bind idx_exec idx_exec_chk u_chk (.clk(clk), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

//--- idx_file_mem.v
// Data register file: one write port, registered read port
`timescale 1ns/10ps
module idx_file_mem #(
   parameter AW = 7,
   parameter DW = 8
) (
   input wire clk, // Core clock
   input wire wr_en, // Write strobe
   input wire [AW-1:0] wr_addr, // Write address
   input wire [DW-1:0] wr_data, // Write data
   input wire [AW-1:0] rd_addr, // Read address
   output reg [DW-1:0] rd_data // Read data, one cycle after address
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Registered read keeps the read path off the execute adder
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // idx_file_mem

//--- idx_host.sv
// Avalon-MM master model standing for the software side
`timescale 1ns/10ps
module idx_host (
   input wire clk, // Core clock
   output logic [4:0] avs_address, // Address
   output logic avs_read, // Read
   output logic avs_write, // Write
   output logic [31:0] avs_writedata, // Write data
   input wire [31:0] avs_readdata, // Read data
   input wire avs_waitrequest // Wait
);
   // Idle bus at time zero
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // One word; request held until wait is sampled low, then released
   task automatic xfer(input bit w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q, output bit late);
      int n;
      begin
         late = 1'b1;
         q = 32'h0;
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= !w;
         avs_write <= w;
         for (n = 0; n < 64 && late; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
               q = avs_readdata;
               late = 1'b0;
            end
         end
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         // Released write data show garbage, not the last value; the address keeps its last value
         avs_writedata <= ~d;
         // One edge apart so no signal is assigned twice in a step
         @(posedge clk);
      end
   endtask
endmodule // idx_host

//--- idx_regs.vh
// Register offsets, field layouts, opcodes and reset values for the instruction executor
`ifndef IDX_REGS_VH
`define IDX_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets (one 32-bit word each)
// ----------------------------------------------------------------
`define IDX_OFS_INSTR 5'h00
`define IDX_OFS_ACC 5'h04
`define IDX_OFS_STATUS 5'h08
`define IDX_OFS_PAGE 5'h0c
`define IDX_OFS_PC 5'h10
`define IDX_OFS_CYCLES 5'h14
`define IDX_OFS_FADDR 5'h18
`define IDX_OFS_FDATA 5'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IDX_ST_ZERO 0
`define IDX_ST_SKIP 1
`define IDX_ST_BUSY 2
`define IDX_DEST_BIT 7
`define IDX_PAGE_HI 4
`define IDX_PAGE_LO 3

// ----------------------------------------------------------------
// Opcode patterns (14-bit instruction word)
// ----------------------------------------------------------------
`define IDX_OP_DSKIP 6'h0b
`define IDX_OP_ISKIP 6'h0f
`define IDX_OP_INC 6'h0a
`define IDX_OP_JUMP 3'h5
`define IDX_OP_ORLIT 6'h38

// ----------------------------------------------------------------
// Reset values and cycle costs
// ----------------------------------------------------------------
`define IDX_RST_ACC 8'h00
`define IDX_RST_PAGE 5'h00
`define IDX_RST_PC 13'h0000
`define IDX_CYC_ONE 16'h0001
`define IDX_CYC_TWO 16'h0002

`endif
